//--- verilog/sspc_top.sv
// strap address sensing, end-switch snapshot and circular position control
// assumes async comparator pins and same-clock status flags
//
// Contract
// - position wraps circularly per step mode range
// - new target picks shorter circular direction
// - high and low sense drives alternate, never both
// - one sense pulse per 1024 us
// - comparator debounced 64 us before use
// - comparator 1 sets High or Low
// - comparator 0 drops to Float per side
// - strap state gives address bit or float
// - Float held 64 ms starts secure move
// - end switch open 0, closed 1
// - switch and position update on pulses only
// - switch and position latched together
// - position frame layout with checksum
// - power-up within 10 ms, then standby
// - power-up loads reset and stored values
// - bridge high impedance after reset
// - soft stop ramps, then target takes position
// - new target only when thermal, electrical ok (secure move loads its target regardless)
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module sspc_top
  import sspc_pkg::*;
#(
  parameter int SENSE_CYC   = SENSE_PERIOD_CYC,
  parameter int FLOAT_CYC   = FLOAT_DEB_CYC,
  parameter int PWRUP_CYC   = POWERUP_CYC,
  parameter int STEP_CYC    = 1000,
  parameter int DECEL_STEPS = 8
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // strap and switch sensing
  input  wire logic        strap_comparator_out,
  input  wire logic        end_switch_pin,
  output logic             high_side_sense_drive,
  output logic             low_side_sense_drive,
  output logic             strap_address_bit,
  output logic             strap_floating,
  // status flags from neighbouring blocks
  input  wire logic        logic_supply_reset_flag,
  input  wire logic        step_loss_flag,
  input  wire logic        electrical_defect_flag,
  input  wire logic        undervoltage_flag,
  input  wire logic        thermal_shutdown_flag,
  input  wire logic        thermal_warning_flag,
  input  wire logic [1:0]  temperature_info,
  input  wire logic [5:0]  node_address_upper,
  // stored configuration
  input  wire logic        nv_step_mode,
  input  wire logic [15:0] nv_secure_position,
  // motion side
  output logic             step_pulse,
  output logic             step_dir_neg,
  output logic             bridge_hiz,
  output logic             secure_move_start,
  output logic             standby_ready
);

  // pin synchronisers
  logic       scmp_s1_q, scmp_s2_q;      // strap comparator stages
  logic       sw_s1_q, sw_s2_q;          // switch comparator stages
  // sense sequencer
  logic [15:0] period_cnt_q;             // period position
  logic        side_q;                   // 1: high-side turn
  logic        pulse_end;                // last cycle of a pulse
  logic        cmp_last_q;               // last synced comparator
  logic [15:0] stable_cnt_q;             // stable run length
  logic        deb_ok;                   // debounced value is usable
  // strap machine
  sspc_strap_t strap_q;                  // strap decision
  logic        float_armed_q;            // float by transition
  logic [19:0] float_cnt_q;              // float persistence
  logic        secure_fire;              // secure move request
  // snapshot
  logic        esw_q;                    // end-switch state
  logic [15:0] snap_pos_q;               // position at that pulse
  // power-up
  logic        load_q;                   // load pending
  logic [19:0] pu_cnt_q;                 // power-up timer
  logic        pu_done_q;                // standby reached
  // motion
  sspc_move_t  mv_q;                     // motion state
  logic        mode16_q;                 // 1: sixteenth micro-step
  logic [15:0] act_pos_q;                // actual position
  logic [15:0] tgt_pos_q;                // target position
  logic        dir_q;                    // 1: decreasing
  logic [15:0] step_cnt_q;               // step timer
  logic [7:0]  decel_left_q;             // steps left in ramp
  logic        step_tick;                // step due this cycle
  logic [15:0] diff;                     // circular distance
  logic        at_tgt;                   // actual equals target
  logic        stop_req;                 // soft stop write
  logic        cmd_wr;                   // target write
  logic        cmd_ok;                   // motion permitted
  logic [31:0] tgt_wr;                   // merged target write
  logic [15:0] new_diff;                 // distance to new target
  logic [15:0] act_step;                 // position one step on
  // bus
  logic        aw_have_q, w_have_q;      // captured halves
  logic [7:0]  aw_addr_q;                // captured write address
  logic [31:0] w_data_q;                 // captured write data
  logic [3:0]  w_strb_q;                 // captured strobes
  logic        wr_fire;                  // write performed now
  logic [31:0] frame_word;               // data bytes 1 to 4
  logic [7:0]  csum;                     // frame checksum
  logic [31:0] rd_mux;                   // read data select
  logic        rd_hit;                   // read address mapped

  // fold a position into the step mode range
  function automatic logic [15:0] wrap_pos(input logic [15:0] p, input logic m16);
    wrap_pos = m16 ? p : {{3{p[HALF_SIGN_BIT]}}, p[HALF_SIGN_BIT:0]};
  endfunction

  // merge a word under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
  endfunction

  // two-stage synchronisers for both comparators
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scmp_s1_q <= 1'b0;
      scmp_s2_q <= 1'b0;
      sw_s1_q   <= 1'b0;
      sw_s2_q   <= 1'b0;
    end else begin
      scmp_s1_q <= strap_comparator_out;
      scmp_s2_q <= scmp_s1_q;
      sw_s1_q   <= end_switch_pin;
      sw_s2_q   <= sw_s1_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_cnt_q <= 16'h0000;
      side_q       <= 1'b0;
    end else if (period_cnt_q == 16'(SENSE_CYC - 1)) begin
      period_cnt_q <= 16'h0000;
      side_q       <= ~side_q;
    end else begin
      period_cnt_q <= period_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_side_sense_drive <= 1'b0;
      low_side_sense_drive  <= 1'b0;
    end else begin
      high_side_sense_drive <= (period_cnt_q < 16'(PULSE_CYC)) & side_q;
      low_side_sense_drive  <= (period_cnt_q < 16'(PULSE_CYC)) & ~side_q;
    end
  end

  assign pulse_end = period_cnt_q == 16'(PULSE_CYC);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_last_q   <= 1'b0;
      stable_cnt_q <= 16'h0000;
    end else begin
      cmp_last_q <= scmp_s2_q;
      if (!(high_side_sense_drive | low_side_sense_drive)) begin
        stable_cnt_q <= 16'h0000;
      end else if (scmp_s2_q != cmp_last_q) begin
        stable_cnt_q <= 16'h0000;
      end else if (stable_cnt_q < 16'(CMP_DEBOUNCE_CYC)) begin
        stable_cnt_q <= stable_cnt_q + 16'h0001;
      end
    end
  end

  assign deb_ok = stable_cnt_q == 16'(CMP_DEBOUNCE_CYC);

  // strap decision, evaluated once per pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_q       <= ST_FLOAT;
      float_armed_q <= 1'b0;
    end else if (pulse_end && deb_ok) begin
      case (strap_q)
        ST_FLOAT, ST_LOW, ST_HIGH: begin
          if (cmp_last_q) begin
            strap_q <= side_q ? ST_LOW : ST_HIGH;
          end else if (!side_q && strap_q == ST_HIGH) begin
            strap_q       <= ST_FLOAT;
            float_armed_q <= 1'b1;
          end else if (side_q && strap_q == ST_LOW) begin
            strap_q       <= ST_FLOAT;
            float_armed_q <= 1'b1;
          end
        end
        default: strap_q <= ST_FLOAT;
      endcase
    end else if (strap_q != ST_FLOAT) begin
      float_armed_q <= 1'b0;
    end
  end

  assign strap_address_bit = strap_q == ST_HIGH;
  assign strap_floating    = strap_q == ST_FLOAT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      float_cnt_q <= 20'h00000;
    end else if (!float_armed_q || strap_q != ST_FLOAT) begin
      float_cnt_q <= 20'h00000;
    end else if (float_cnt_q != 20'(FLOAT_CYC)) begin
      float_cnt_q <= float_cnt_q + 20'h00001;
    end
  end

  assign secure_fire = float_cnt_q == 20'(FLOAT_CYC - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      secure_move_start <= 1'b0;
    end else begin
      secure_move_start <= secure_fire & pu_done_q;
    end
  end

  // switch and position snapshot on each pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      esw_q      <= 1'b0;
      snap_pos_q <= POS_RST;
    end else if (pulse_end) begin
      esw_q      <= sw_s2_q;
      snap_pos_q <= act_pos_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_q    <= 1'b1;
      pu_cnt_q  <= 20'h00000;
      pu_done_q <= 1'b0;
    end else begin
      load_q <= 1'b0;
      if (pu_cnt_q == 20'(PWRUP_CYC - 1)) begin
        pu_done_q <= 1'b1;
      end else begin
        pu_cnt_q <= pu_cnt_q + 20'h00001;
      end
    end
  end

  assign standby_ready = pu_done_q;
  assign bridge_hiz = ~pu_done_q;

  // step mode: stored, then software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode16_q <= 1'b0;
    end else if (load_q) begin
      mode16_q <= nv_step_mode;
    end else if (wr_fire && aw_addr_q == OFS_CTRL && w_strb_q[0]) begin
      mode16_q <= w_data_q[CTRL_MODE_BIT];
    end
  end

  assign stop_req = wr_fire && aw_addr_q == OFS_CTRL && w_strb_q[0] && w_data_q[CTRL_STOP_BIT];
  assign cmd_wr   = wr_fire && aw_addr_q == OFS_TARGET;
  assign cmd_ok   = pu_done_q & ~thermal_shutdown_flag & ~electrical_defect_flag
                    & (mv_q != MV_DECEL);
  assign diff     = wrap_pos(tgt_pos_q - act_pos_q, mode16_q);
  assign at_tgt   = diff == 16'h0000;
  assign step_tick = step_cnt_q == 16'(STEP_CYC - 1);
  assign tgt_wr    = merge({16'h0000, tgt_pos_q}, w_data_q, w_strb_q);
  assign new_diff  = wrap_pos(tgt_wr[15:0] - act_pos_q, mode16_q);
  assign act_step  = wrap_pos(dir_q ? act_pos_q - 16'h0001 : act_pos_q + 16'h0001, mode16_q);

  // step rate timer
  always_ff @(posedge aclk) begin
    if (!aresetn || mv_q == MV_IDLE || step_tick) begin
      step_cnt_q <= 16'h0000;
    end else begin
      step_cnt_q <= step_cnt_q + 16'h0001;
    end
  end

  // target register and direction choice
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tgt_pos_q <= TARGET_RST;
      dir_q     <= 1'b0;
    end else if (mv_q == MV_DECEL && step_tick && (decel_left_q == 8'h01 || at_tgt)) begin
      // ramp end: target takes actual, including a step landing now
      tgt_pos_q <= at_tgt ? act_pos_q : act_step;
    end else if (secure_fire && pu_done_q) begin
      tgt_pos_q <= wrap_pos(nv_secure_position, mode16_q);
      dir_q     <= wrap_pos(nv_secure_position - act_pos_q, mode16_q) >> 15 != 16'h0000;
    end else if (cmd_wr && cmd_ok) begin
      tgt_pos_q <= wrap_pos(tgt_wr[15:0], mode16_q);
      dir_q     <= new_diff[15];
    end
  end

  // motion state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mv_q         <= MV_IDLE;
      decel_left_q <= 8'h00;
    end else begin
      case (mv_q)
        MV_IDLE: begin
          if (!at_tgt && pu_done_q) mv_q <= MV_RUN;
        end
        MV_RUN: begin
          if (stop_req) begin
            mv_q         <= MV_DECEL;
            decel_left_q <= 8'(DECEL_STEPS);
          end else if (at_tgt) begin
            mv_q <= MV_IDLE;
          end
        end
        MV_DECEL: begin
          if (step_tick) begin
            decel_left_q <= decel_left_q - 8'h01;
            if (decel_left_q == 8'h01 || at_tgt) mv_q <= MV_IDLE;
          end
        end
        default: mv_q <= MV_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_pos_q  <= POS_RST;
      step_pulse <= 1'b0;
    end else begin
      step_pulse <= 1'b0;
      if (mv_q != MV_IDLE && step_tick && !at_tgt) begin
        act_pos_q  <= act_step;
        step_pulse <= 1'b1;
      end
    end
  end

  assign step_dir_neg = dir_q;

  // position frame bytes 1 to 4
  assign frame_word = {esw_q, node_address_upper, strap_address_bit, snap_pos_q,
                       logic_supply_reset_flag, step_loss_flag, electrical_defect_flag,
                       undervoltage_flag, thermal_shutdown_flag, thermal_warning_flag,
                       temperature_info};

  always_comb begin
    logic [8:0] acc;
    acc = 9'h000;
    for (int i = 3; i >= 0; i--) begin
      acc = {1'b0, acc[7:0]} + {1'b0, frame_word[8*i +: 8]} + {8'h00, acc[8]};
    end
    acc  = {1'b0, acc[7:0]} + {8'h00, acc[8]};
    csum = ~acc[7:0];
  end

  // write channel capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
  assign wr_fire       = aw_have_q & w_have_q & ~s_axi_bvalid;

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_q == OFS_CTRL || aw_addr_q == OFS_TARGET) ? RESP_OKAY
                                                                         : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read decode
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFS_CTRL:   rd_mux = {31'h00000000, mode16_q};
      OFS_TARGET: rd_mux = {16'h0000, tgt_pos_q};
      OFS_FRAME:  rd_mux = frame_word;
      OFS_CSUM:   rd_mux = {24'h000000, csum};
      OFS_STATUS: rd_mux = {24'h000000, pu_done_q, mv_q, float_armed_q, strap_q};
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  // read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- verilog/sspc_pkg.sv
// package for the strap, switch sense and position block
// assumes a 10 MHz clock and a 32-bit AXI4-Lite bus
package sspc_pkg;
  // clock rate in MHz, used to turn times into cycles
  localparam int CLK_MHZ          = 10;
  // timing figures in their own units
  localparam int SENSE_PERIOD_US  = 1024;
  localparam int CMP_DEBOUNCE_US  = 64;
  localparam int FLOAT_DEBOUNCE_MS = 64;
  localparam int POWERUP_MS       = 10;
  // derived cycle counts
  localparam int SENSE_PERIOD_CYC = SENSE_PERIOD_US * CLK_MHZ;
  localparam int CMP_DEBOUNCE_CYC = CMP_DEBOUNCE_US * CLK_MHZ;
  localparam int PULSE_CYC        = 2 * CMP_DEBOUNCE_CYC;
  localparam int FLOAT_DEB_CYC    = FLOAT_DEBOUNCE_MS * 1000 * CLK_MHZ;
  localparam int POWERUP_CYC      = POWERUP_MS * 1000 * CLK_MHZ;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TARGET = 8'h04;
  localparam logic [7:0] OFS_FRAME  = 8'h08;
  localparam logic [7:0] OFS_CSUM   = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // control field positions
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  // reset values
  localparam logic [15:0] TARGET_RST = 16'h0000;
  localparam logic [15:0] POS_RST    = 16'h0000;
  // half-step position sign bit
  localparam int HALF_SIGN_BIT = 12;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // strap decision states
  typedef enum logic [2:0] {
    ST_FLOAT = 3'b001,
    ST_LOW   = 3'b010,
    ST_HIGH  = 3'b100
  } sspc_strap_t;
  // motion states
  typedef enum logic [2:0] {
    MV_IDLE  = 3'b001,
    MV_RUN   = 3'b010,
    MV_DECEL = 3'b100
  } sspc_move_t;
endpackage

//--- tb/sspc_assertions.sv
// checker for sspc_top sense, strap and power-up
// assumes a bind into sspc_top, ports only
`timescale 1ns/1ps
module sspc_assertions
  import sspc_pkg::*;
#(
  parameter int SENSE_CYC = SENSE_PERIOD_CYC,
  parameter int FLOAT_CYC = FLOAT_DEB_CYC,
  parameter int PWRUP_CYC = POWERUP_CYC
) (
  // clock, reset and read answer
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  // sensing and motion outputs
  input wire logic       high_side_sense_drive,
  input wire logic       low_side_sense_drive,
  input wire logic       strap_address_bit,
  input wire logic       strap_floating,
  input wire logic       step_pulse,
  input wire logic       bridge_hiz,
  input wire logic       secure_move_start,
  input wire logic       standby_ready
);
  wire logic drv = high_side_sense_drive | low_side_sense_drive; // any pulse
  int   hi_q;      // pulse length
  int   per_q;     // cycles since pulse start
  int   fl_q;      // float time
  int   pu_q;      // time since reset
  logic last_hs_q; // last side
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // pulse width, period and side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_q <= 0;
      per_q <= -SENSE_CYC;
      last_hs_q <= 1'b1;
    end else begin
      hi_q <= drv ? hi_q + 1 : 0;
      per_q <= (drv && hi_q == 0) ? 0 : per_q + 1;
      if (drv && hi_q == 0) last_hs_q <= high_side_sense_drive;
    end
  end
  // float and power-up time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fl_q <= 0;
      pu_q <= 0;
    end else begin
      fl_q <= strap_floating ? fl_q + 1 : 0;
      pu_q <= pu_q + 1;
    end
  end
  a_drive_excl: assert property (!(high_side_sense_drive && low_side_sense_drive))
    else $error("drives overlap");
  a_side_alt: assert property ($rose(drv) |-> high_side_sense_drive != last_hs_q)
    else $error("side repeated");
  a_pulse_width: assert property ($fell(drv) |-> hi_q == PULSE_CYC)
    else $error("pulse width");
  a_pulse_period: assert property ($rose(drv) && per_q >= 0 |-> per_q == SENSE_CYC - 1)
    else $error("period");
  a_state_sync: assert property ($changed({strap_floating, strap_address_bit}) |-> per_q inside {[PULSE_CYC - 1 : PULSE_CYC + 2]})
    else $error("strap changed off pulse end");
  a_float_addr: assert property (strap_floating |-> !strap_address_bit)
    else $error("address while floating");
  a_secure_wait: assert property (secure_move_start |-> strap_floating && fl_q >= FLOAT_CYC - 1)
    else $error("secure move early");
  a_hiz_ready: assert property (bridge_hiz != standby_ready)
    else $error("bridge vs standby");
  a_pwrup_time: assert property (bridge_hiz |-> pu_q <= PWRUP_CYC + 1)
    else $error("power-up slow");
  a_step_hiz: assert property (step_pulse |-> !bridge_hiz)
    else $error("step while off");
  c_secure: cover property (secure_move_start);
  c_high: cover property (strap_address_bit);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
bind sspc_top sspc_assertions #(.SENSE_CYC(SENSE_CYC), .FLOAT_CYC(FLOAT_CYC),
  .PWRUP_CYC(PWRUP_CYC)) sspc_assertions_i (.*);

//--- tb/sspc_strap_model.sv
// strap resistor and end switch outside sspc_top
// assumes instant comparator; no drive, no current
`timescale 1ns/1ps
module sspc_strap_model (
  // sense drives from the block
  input  wire logic       high_side_sense_drive,
  input  wire logic       low_side_sense_drive,
  // wiring: 0 ground, 1 battery, 2 open; switch state
  input  wire logic [1:0] strap_mode,
  input  wire logic       switch_closed,
  // comparator answers
  output logic            strap_comparator_out,
  output logic            end_switch_pin
);
  assign strap_comparator_out = (high_side_sense_drive && strap_mode == 2'h0) ||
                                (low_side_sense_drive && strap_mode == 2'h1);
  assign end_switch_pin = switch_closed;
endmodule

//--- tb/sspc_tb_top.sv
// testbench for sspc_top
// assumes package, checker and model compiled first
`timescale 1ns/1ps
module sspc_tb_top;
  import sspc_pkg::*;
  localparam int SC = 1400;             // shortened sense period
  localparam int DECEL = 8;             // ramp steps after a stop
  localparam logic [5:0] NODE = 6'h2A;  // upper node address
  // row: wiring, switch, flags, expected float, address
  typedef struct packed {logic [1:0] m; logic sw; logic [7:0] fl; logic f; logic a;} sspc_row_t;
  sspc_row_t rows [7] = '{'{2'h1, 1'b0, 8'h96, 1'b0, 1'b1}, '{2'h2, 1'b1, 8'h41, 1'b1, 1'b0},
    '{2'h0, 1'b0, 8'h2C, 1'b0, 1'b0}, '{2'h2, 1'b1, 8'h10, 1'b1, 1'b0},
    '{2'h0, 1'b1, 8'h00, 1'b0, 1'b0}, '{2'h1, 1'b0, 8'hFF, 1'b0, 1'b1},
    '{2'h0, 1'b0, 8'hC3, 1'b0, 1'b0}};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, sw;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, flg;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, e;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, mode;
  logic strap_comparator_out, end_switch_pin, high_side_sense_drive, low_side_sense_drive;
  logic strap_address_bit, strap_floating, step_pulse, step_dir_neg, bridge_hiz;
  logic secure_move_start, standby_ready;
  logic [15:0] p;
  int n_errors = 0, compares = 0, n_up = 0, n_dn = 0, t;
  always #50 aclk = ~aclk;
  sspc_top #(.SENSE_CYC(SC), .FLOAT_CYC(50), .PWRUP_CYC(20), .STEP_CYC(4), .DECEL_STEPS(DECEL))
  sspc_top_i (.*, .logic_supply_reset_flag(flg[7]), .step_loss_flag(flg[6]),
    .electrical_defect_flag(flg[5]), .undervoltage_flag(flg[4]), .thermal_shutdown_flag(flg[3]),
    .thermal_warning_flag(flg[2]), .temperature_info(flg[1:0]), .node_address_upper(NODE),
    .nv_step_mode(1'b0), .nv_secure_position(16'h0000));
  sspc_strap_model sspc_strap_model_i (.high_side_sense_drive, .low_side_sense_drive,
    .strap_mode(mode), .switch_closed(sw), .strap_comparator_out, .end_switch_pin);
  // step counts
  always @(posedge aclk) begin
    if (step_pulse && step_dir_neg) n_dn++;
    else if (step_pulse) n_up++;
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  // write: aw and w together, each freed when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] q);
    logic ka, kw, kb;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(negedge aclk);
      {ka, kw, kb} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid};
      q = s_axi_bresp;
      @(posedge aclk);
      if (ka) s_axi_awvalid <= 1'b0;
      if (kw) s_axi_wvalid <= 1'b0;
    end while (!kb);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] q);
    logic ka, kr;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(negedge aclk);
      {ka, kr, v, q} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ka) s_axi_arvalid <= 1'b0;
    end while (!kr);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // end-around carry sum, inverted
  function automatic logic [7:0] csum(input logic [31:0] f);
    logic [8:0] s;
    s = 9'h000;
    for (int k = 0; k < 4; k++) begin
      s = s + f[8*k +: 8];
      if (s[8]) s = s - 9'h0FF;
    end
    return ~s[7:0];
  endfunction
  // wait idle, then a snapshot
  task automatic idle_wait();
    logic [31:0] v;
    v = 32'h0;
    for (int k = 0; k < 9000 && v[4] !== 1'b1; k++) begin
      repeat (20) @(posedge aclk);
      rd(OFS_STATUS, v, r);
    end
    repeat (2 * SC) @(posedge aclk);
  endtask
  task automatic results();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge aclk);
    n_errors++;
    results();
  end
  initial begin
    aclk = 1'b0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sw} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, flg} = '0;
    s_axi_wstrb = 4'hF;
    mode = 2'h2;
    repeat (6) @(posedge aclk);
    chk("hiz", 1, bridge_hiz);
    chk("float", 1, strap_floating);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_CTRL, d, r);
    chk("ctrl", 0, d);
    wr(OFS_TARGET, 32'h55, r);
    rd(OFS_TARGET, d, r);
    chk("target", 0, d);
    repeat (30) @(posedge aclk);
    chk("ready", 1, standby_ready);
    $display("test reset done");
    foreach (rows[i]) begin
      {mode, sw, flg} <= {rows[i].m, rows[i].sw, rows[i].fl};
      repeat (2 * SC + 20) @(posedge aclk);
      @(negedge aclk);
      chk("strap", {rows[i].f, rows[i].a}, {strap_floating, strap_address_bit});
      @(posedge aclk);
      rd(OFS_FRAME, d, r);
      chk("frame", {rows[i].sw, NODE, rows[i].a, rows[i].fl}, {d[31:24], d[7:0]});
    end
    rd(OFS_CSUM, e, r);
    chk("csum", csum({1'b0, NODE, 1'b0, 16'h0000, 8'hC3}), e[7:0]);
    $display("test strap table done");
    wr(OFS_TARGET, 32'hFFF6, r);
    idle_wait();
    chk("down", 10, n_dn);
    wr(OFS_TARGET, 32'h0FFA, r);
    idle_wait();
    chk("wrap", {16'd4102, 16'd0}, {n_dn[15:0], n_up[15:0]});
    rd(OFS_FRAME, d, r);
    chk("pos", 16'h0FFA, d[23:8]);
    wr(OFS_TARGET, 32'h0, r);
    repeat (200) @(posedge aclk);
    wr(OFS_CTRL, 32'h2, r);
    t = n_dn;
    idle_wait();
    // one step may land as the write ends
    chk("ramp", 1, n_dn - t <= DECEL + 1);
    p = 16'h0FFA - 16'(n_dn - 4102);
    rd(OFS_FRAME, d, r);
    rd(OFS_TARGET, e, r);
    chk("stop", {p, p}, {d[23:8], e[15:0]});
    $display("test motion done");
    for (int k = 0; k < 2; k++) begin
      flg <= k ? 8'h20 : 8'h08;
      @(posedge aclk);
      t = n_dn + n_up;
      wr(OFS_TARGET, 32'h10, r);
      repeat (100) @(posedge aclk);
      rd(OFS_TARGET, e, r);
      chk("held", {p, t[15:0]}, {e[15:0], 16'(n_dn + n_up)});
    end
    flg <= 8'h00;
    @(posedge aclk);
    wr(OFS_TARGET, {16'h0, p + 16'd20}, r);
    idle_wait();
    rd(OFS_FRAME, d, r);
    chk("up", {p + 16'd20, 16'd20}, {d[23:8], n_up[15:0]});
    rd(8'h14, d, r);
    chk("unmapped", {RESP_SLVERR, 30'h0}, {r, d[29:0]});
    wr(OFS_FRAME, 32'hFFFFFFFF, r);
    chk("ro", RESP_SLVERR, r);
    wr(OFS_CTRL, 32'h3, r);
    rd(OFS_CTRL, d, r);
    chk("ctrl", 1, d);
    $display("test refusals done");
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("rehiz", {2'h3, 1'b0}, {bridge_hiz, strap_floating, standby_ready});
    aresetn <= 1'b1;
    repeat (30) @(posedge aclk);
    $display("test second reset done");
    results();
  end
endmodule
